// ==== inc/fanout_pkg.sv ====
// constants and types shared by the clock fan-out control logic
package fanout_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int REF_MIN_FREQ_KHZ = 2000;
  localparam int REF_MIN_PERIOD_PS = 1000000000 / REF_MIN_FREQ_KHZ;
  // longest gap before power-down, rounded down to whole cycles
  localparam int MISS_CYCLES_INT = REF_MIN_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [7:0] MISS_CYCLES = 8'(MISS_CYCLES_INT);
  localparam logic [7:0] GAP_RESET = MISS_CYCLES;

  // ==========================================================
  // phase-aligned reference edges needed to declare lock
  localparam logic [2:0] LOCK_EDGES = 3'h4;
  localparam logic [2:0] LOCK_RESET = 3'h0;

  // ==========================================================
  // select codes, {select_bit_high, select_bit_low}
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_A_ONLY = 2'h1;
  localparam logic [1:0] SEL_BYPASS = 2'h2;
  localparam logic [1:0] SEL_ALL = 2'h3;
  // open select pins read high
  localparam logic [1:0] SEL_RESET = SEL_ALL;

  // ==========================================================
  // fan-out widths
  localparam int BANK_WIDTH = 4;

  typedef enum logic [1:0] {
    ST_POWER_DOWN,
    ST_ACQUIRE,
    ST_LOCKED,
    ST_BYPASS
  } fanout_state_type;

endpackage

// ==== design/ref_edge_monitor.sv ====
// reference pin synchroniser, rising edge detect and missing-edge timer
module ref_edge_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // reference pin
  input wire logic ref_pin,
  // filtered view
  output logic ref_level,
  output logic ref_rise,
  output logic ref_absent
);

  logic meta_q;
  logic mid_q;
  logic late_q;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire agree = (mid_q == late_q);
  wire at_limit = (cnt_q == fanout_pkg::MISS_CYCLES);

  // ==========================================================
  // filtering
  // a change counts once the second and third stage agree
  assign level_d = agree ? late_q : level_q;
  // saturate so a stopped reference stays absent forever
  assign cnt_d = rise_q ? 8'h00 : (at_limit ? cnt_q : cnt_q + 8'h01);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      mid_q <= 1'b0;
      late_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      cnt_q <= fanout_pkg::GAP_RESET;
    end else begin
      meta_q <= ref_pin;
      mid_q <= meta_q;
      late_q <= mid_q;
      level_q <= level_d;
      rise_q <= level_d & ~level_q;
      cnt_q <= cnt_d;
    end
  end

  assign ref_level = level_q;
  assign ref_rise = rise_q;
  assign ref_absent = at_limit;

endmodule

// ==== design/zero_delay_clock_fanout_ctrl.sv ====
// control logic of a nine-output zero-delay clock fan-out buffer
module zero_delay_clock_fanout_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // reference and select pins
  input wire logic ref_pin,
  input wire logic select_bit_low,
  input wire logic select_bit_high,
  // bank A pins, oe low while driving
  output logic [3:0] bank_a_output,
  output logic bank_a_oe_n,
  // second_output_group pins, oe low while driving
  output logic [3:0] bank_b_output,
  output logic bank_b_oe_n,
  // feedback pin, oe low while driving
  output logic feedback_output,
  output logic feedback_oe_n,
  // weak pull enables for the pad ring
  output logic select_pullup_en,
  output logic output_pulldown_en,
  // status
  output logic pll_enable,
  output logic pll_locked,
  output logic power_down
);

  // ==========================================================
  // decode helpers
  function automatic logic bank_a_on(input logic [1:0] sel);
    bank_a_on = (sel != fanout_pkg::SEL_OFF);
  endfunction

  function automatic logic bank_b_on(input logic [1:0] sel);
    bank_b_on = sel[1];
  endfunction

  // ==========================================================
  // reference monitor
  logic ref_level;
  logic ref_rise;
  logic ref_absent;

  ref_edge_monitor u_ref_mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ref_pin(ref_pin),
    .ref_level(ref_level),
    .ref_rise(ref_rise),
    .ref_absent(ref_absent)
  );

  // ==========================================================
  // select synchronisers
  logic [1:0] sel_meta_q;
  logic [1:0] sel_mid_q;
  logic [1:0] sel_late_q;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  wire [1:0] sel_pins = {select_bit_high, select_bit_low};
  wire sel_agree = (sel_mid_q == sel_late_q);

  assign sel_d = sel_agree ? sel_late_q : sel_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_meta_q <= fanout_pkg::SEL_RESET;
      sel_mid_q <= fanout_pkg::SEL_RESET;
      sel_late_q <= fanout_pkg::SEL_RESET;
      sel_q <= fanout_pkg::SEL_RESET;
    end else begin
      sel_meta_q <= sel_pins;
      sel_mid_q <= sel_meta_q;
      sel_late_q <= sel_mid_q;
      sel_q <= sel_d;
    end
  end

  // ==========================================================
  // mode state machine
  fanout_pkg::fanout_state_type state_q;
  fanout_pkg::fanout_state_type state_d;
  logic [2:0] lock_q;
  logic [2:0] lock_d;

  wire sel_bypass = (sel_q == fanout_pkg::SEL_BYPASS);
  // feedback pad is read back as the phase reference of the loop
  wire phase_ok = ref_rise & ~feedback_output;
  wire lock_last = (lock_q == fanout_pkg::LOCK_EDGES - 3'h1);
  wire in_pd = (state_q == fanout_pkg::ST_POWER_DOWN);
  wire in_bypass = (state_q == fanout_pkg::ST_BYPASS);
  wire pll_run = (state_q == fanout_pkg::ST_ACQUIRE) ||
                 (state_q == fanout_pkg::ST_LOCKED);

  always_comb begin
    state_d = state_q;
    lock_d = lock_q;
    if (sel_bypass) begin
      state_d = fanout_pkg::ST_BYPASS;
      lock_d = fanout_pkg::LOCK_RESET;
    end else if (ref_absent) begin
      state_d = fanout_pkg::ST_POWER_DOWN;
      lock_d = fanout_pkg::LOCK_RESET;
    end else begin
      case (state_q)
        fanout_pkg::ST_POWER_DOWN,
        fanout_pkg::ST_BYPASS: begin
          state_d = fanout_pkg::ST_ACQUIRE;
          lock_d = fanout_pkg::LOCK_RESET;
        end
        fanout_pkg::ST_ACQUIRE: begin
          if (ref_rise) begin
            if (!phase_ok) begin
              lock_d = fanout_pkg::LOCK_RESET;
            end else if (lock_last) begin
              state_d = fanout_pkg::ST_LOCKED;
              lock_d = fanout_pkg::LOCK_RESET;
            end else begin
              lock_d = lock_q + 3'h1;
            end
          end
        end
        fanout_pkg::ST_LOCKED: begin
          // a misaligned edge means the loop slipped; reacquire
          if (ref_rise && !phase_ok) begin
            state_d = fanout_pkg::ST_ACQUIRE;
          end
        end
        default: begin
          state_d = fanout_pkg::ST_POWER_DOWN;
          lock_d = fanout_pkg::LOCK_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= fanout_pkg::ST_POWER_DOWN;
      lock_q <= fanout_pkg::LOCK_RESET;
    end else begin
      state_q <= state_d;
      lock_q <= lock_d;
    end
  end

  // ==========================================================
  // source selection and output enables
  // the PLL path is modelled as a copy of the reference it tracks
  wire pll_clk = pll_run & ref_level;
  wire clk_src = in_bypass ? ref_level : pll_clk;
  wire a_drive = !in_pd && (in_bypass || bank_a_on(sel_q));
  wire b_drive = !in_pd && (in_bypass || bank_b_on(sel_q));
  // feedback stays driven under every code, only power-down floats it
  wire fb_drive = !in_pd;
  // floated outputs are driven low so they match the pad pull-down
  wire [3:0] a_val = {fanout_pkg::BANK_WIDTH{clk_src & a_drive}};
  wire [3:0] b_val = {fanout_pkg::BANK_WIDTH{clk_src & b_drive}};
  wire fb_val = clk_src & fb_drive;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bank_a_output <= 4'h0;
      bank_b_output <= 4'h0;
      feedback_output <= 1'b0;
      bank_a_oe_n <= 1'b1;
      bank_b_oe_n <= 1'b1;
      feedback_oe_n <= 1'b1;
      pll_enable <= 1'b0;
      pll_locked <= 1'b0;
      power_down <= 1'b1;
      select_pullup_en <= 1'b1;
      output_pulldown_en <= 1'b1;
    end else begin
      bank_a_output <= a_val;
      bank_b_output <= b_val;
      feedback_output <= fb_val;
      bank_a_oe_n <= ~a_drive;
      bank_b_oe_n <= ~b_drive;
      feedback_oe_n <= ~fb_drive;
      pll_enable <= pll_run;
      pll_locked <= (state_q == fanout_pkg::ST_LOCKED);
      power_down <= in_pd;
      select_pullup_en <= 1'b1;
      output_pulldown_en <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  default clocking chk_clk @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // independent gap timer to cross-check the missing-edge detector
  logic [7:0] gap_q;
  wire gap_sat = (gap_q > fanout_pkg::MISS_CYCLES);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_q <= fanout_pkg::GAP_RESET;
    end else if (ref_rise) begin
      gap_q <= 8'h00;
    end else if (!gap_sat) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  sequence aligned_last_edge;
    state_q == fanout_pkg::ST_ACQUIRE && lock_last && phase_ok &&
      !sel_bypass && !ref_absent;
  endsequence

  sequence bypass_held;
    in_bypass ##1 in_bypass;
  endsequence

  sel_off_float_a: assert property (
    !in_pd && sel_q == fanout_pkg::SEL_OFF && !in_bypass
    |=> bank_a_oe_n && bank_b_oe_n && !feedback_oe_n)
    else $error("select 00 did not float both banks");

  sel_a_only_a: assert property (
    !in_pd && sel_q == fanout_pkg::SEL_A_ONLY && !in_bypass
    |=> !bank_a_oe_n && bank_b_oe_n)
    else $error("select 01 did not drive bank A alone");

  bypass_source_a: assert property (
    bypass_held |=> !pll_enable && power_down == 1'b0 &&
      bank_b_output == {4{$past(ref_level)}})
    else $error("bypass not sourced from reference");

  bypass_driven_a: assert property (
    sel_bypass ##1 sel_bypass
    |=> !bank_a_oe_n && !bank_b_oe_n && !feedback_oe_n)
    else $error("bypass outputs were floated");

  pll_runs_a: assert property (
    pll_run |=> pll_enable &&
      (bank_a_oe_n || bank_a_output[0] == $past(ref_level)))
    else $error("PLL not running outside bypass");

  missing_edge_a: assert property (
    gap_q == fanout_pkg::MISS_CYCLES && !sel_bypass
    |=> in_pd ##1 power_down)
    else $error("missed reference edges did not power down");

  power_down_a: assert property (
    in_pd |=> bank_a_oe_n && bank_b_oe_n && feedback_oe_n &&
      !pll_enable && bank_a_output == 4'h0)
    else $error("power-down left outputs or PLL on");

  lock_entry_a: assert property (
    aligned_last_edge |=> state_q == fanout_pkg::ST_LOCKED ##1 pll_locked)
    else $error("lock not declared after aligned edges");

  feedback_drive_a: assert property (
    !in_pd |=> !feedback_oe_n && feedback_output == $past(clk_src))
    else $error("feedback output not driven from source");

  fanout_equal_a: assert property (
    !bank_a_oe_n && !bank_b_oe_n
    |-> bank_a_output == bank_b_output &&
      bank_a_output == {4{feedback_output}})
    else $error("fan-out outputs disagree");

  weak_pulls_a: assert property (
    $past(rst_n) |-> select_pullup_en && output_pulldown_en)
    else $error("pad pull enables dropped");

endmodule

// ==== bench/fanout_partner.sv ====
// reference clock source and pad model of the loads and select pins
module fanout_partner (
  // clock
  input wire logic core_clk,
  // reference source
  input wire logic ref_run,
  input wire logic ref_idle_level,
  input wire logic [3:0] ref_half,
  output logic ref_pin,
  // select source
  input wire logic sel_drive_en,
  input wire logic [1:0] sel_value,
  input wire logic select_pullup_en,
  output logic select_bit_low,
  output logic select_bit_high,
  // device pads
  input wire logic [3:0] bank_a_output,
  input wire logic bank_a_oe_n,
  input wire logic [3:0] bank_b_output,
  input wire logic bank_b_oe_n,
  input wire logic feedback_output,
  input wire logic feedback_oe_n,
  input wire logic output_pulldown_en,
  // resolved wire levels seen by the loads
  output logic [3:0] a_wire,
  output logic [3:0] b_wire,
  output logic fb_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // reference; stopping it holds a DC level
  logic [3:0] cnt_q = 4'h0;
  initial ref_pin = 1'b0;
  always @(posedge core_clk) begin
    if (!ref_run) begin
      ref_pin <= ref_idle_level;
      cnt_q <= 4'h0;
    end else if (cnt_q >= ref_half - 4'h1) begin
      ref_pin <= ~ref_pin;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // ==========================================================
  // weak pulls; without one a released wire shows the inverse value
  logic [1:0] sel_wire;
  assign sel_wire = sel_drive_en ? sel_value :
                    (select_pullup_en ? 2'h3 : ~sel_value);
  assign select_bit_low = sel_wire[0];
  assign select_bit_high = sel_wire[1];
  assign a_wire = !bank_a_oe_n ? bank_a_output :
                  (output_pulldown_en ? 4'h0 : ~bank_a_output);
  assign b_wire = !bank_b_oe_n ? bank_b_output :
                  (output_pulldown_en ? 4'h0 : ~bank_b_output);
  assign fb_wire = !feedback_oe_n ? feedback_output :
                   (output_pulldown_en ? 1'b0 : ~feedback_output);
endmodule

// ==== bench/zero_delay_clock_fanout_ctrl_tb.sv ====
// self-checking bench for the clock fan-out control logic
module zero_delay_clock_fanout_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_run = 1'b0;
  logic ref_idle_level = 1'b0;
  logic [3:0] ref_half = 4'h5;
  logic sel_drive_en = 1'b1;
  logic [1:0] sel_value = fanout_pkg::SEL_ALL;
  logic ref_pin, select_bit_low, select_bit_high, select_pullup_en;
  logic [3:0] bank_a_output, bank_b_output, a_wire, b_wire;
  logic bank_a_oe_n, bank_b_oe_n, feedback_output, feedback_oe_n;
  logic output_pulldown_en, pll_enable, pll_locked, power_down, fb_wire;
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 82215;
  logic [1:0] code;
  logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h0, 2'h2};

  initial forever #5 core_clk = ~core_clk;

  zero_delay_clock_fanout_ctrl i_zero_delay_clock_fanout_ctrl (
    .core_clk, .rst_n, .ref_pin, .select_bit_low, .select_bit_high,
    .bank_a_output, .bank_a_oe_n, .bank_b_output, .bank_b_oe_n,
    .feedback_output, .feedback_oe_n, .select_pullup_en,
    .output_pulldown_en, .pll_enable, .pll_locked, .power_down);

  fanout_partner i_fanout_partner (
    .core_clk, .ref_run, .ref_idle_level, .ref_half, .ref_pin,
    .sel_drive_en, .sel_value, .select_pullup_en, .select_bit_low,
    .select_bit_high, .bank_a_output, .bank_a_oe_n, .bank_b_output,
    .bank_b_oe_n, .feedback_output, .feedback_oe_n, .output_pulldown_en,
    .a_wire, .b_wire, .fb_wire);

  // ==========================================================
  // helpers
  function automatic logic [7:0] exp_oe(logic [1:0] c);
    case (c)
      fanout_pkg::SEL_OFF: return 8'h6;
      fanout_pkg::SEL_A_ONLY: return 8'h2;
      default: return 8'h0;
    endcase
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apply(logic [1:0] c, logic run, logic lvl, int n);
    @(posedge core_clk);
    sel_value <= c;
    ref_run <= run;
    ref_idle_level <= lvl;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check("power_down", 8'(power_down), 8'h1);
    check("oe", 8'({bank_a_oe_n, bank_b_oe_n, feedback_oe_n}), 8'h7);
    check("pulls", 8'({select_pullup_en, output_pulldown_en}), 8'h3);
    check("pads", {a_wire, b_wire}, 8'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      code = (i < 4) ? codes[i] : 2'($random(seed));
      @(posedge core_clk);
      ref_half <= 4'(3 + $unsigned($random(seed)) % 6);
      apply(code, 1'b1, 1'b0, 40);
      check("oe", 8'({bank_a_oe_n, bank_b_oe_n, feedback_oe_n}),
            exp_oe(code));
      check("pll_enable", 8'(pll_enable), 8'(code != 2'h2));
      check("power_down", 8'(power_down), 8'h0);
      if (exp_oe(code) == 8'h0)
        check("fanout", {bank_a_output, bank_b_output},
              {8{feedback_output}});
    end
    $display("test select codes done");
    apply(fanout_pkg::SEL_ALL, 1'b1, 1'b0, 300);
    check("pll_locked", 8'(pll_locked), 8'h1);
    check("fb_oe", 8'(feedback_oe_n), 8'h0);
    $display("test lock done");
    // bypass with a DC reference must not fall into power-down
    apply(fanout_pkg::SEL_BYPASS, 1'b0, 1'b1, 100);
    check("oe", 8'({bank_a_oe_n, bank_b_oe_n, feedback_oe_n}), 8'h0);
    check("pads", {a_wire, b_wire}, 8'hFF);
    check("fb", 8'(fb_wire), 8'h1);
    check("pll_enable", 8'(pll_enable), 8'h0);
    apply(fanout_pkg::SEL_BYPASS, 1'b0, 1'b0, 20);
    check("oe", 8'({bank_a_oe_n, bank_b_oe_n, feedback_oe_n}), 8'h0);
    check("pads", {a_wire, b_wire}, 8'h0);
    $display("test bypass done");
    apply(fanout_pkg::SEL_ALL, 1'b1, 1'b0, 40);
    apply(fanout_pkg::SEL_ALL, 1'b0, 1'b0, 30);
    check("power_down", 8'(power_down), 8'h0);
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    check("power_down", 8'(power_down), 8'h1);
    check("oe", 8'({bank_a_oe_n, bank_b_oe_n, feedback_oe_n}), 8'h7);
    check("pll_enable", 8'(pll_enable), 8'h0);
    check("pads", {a_wire, b_wire}, 8'h0);
    check("fb", 8'(fb_wire), 8'h0);
    $display("test power-down done");
    @(posedge core_clk);
    sel_drive_en <= 1'b0;
    apply(fanout_pkg::SEL_OFF, 1'b1, 1'b0, 60);
    check("oe", 8'({bank_a_oe_n, bank_b_oe_n, feedback_oe_n}), 8'h0);
    check("pll_enable", 8'(pll_enable), 8'h1);
    $display("test open selects done");
    print_verdict();
  end
endmodule
